/* File: epi_change_det.sv */
// change detector: sampled level and one combined change pulse for all pins under a mask
`timescale 1ns/1ps
module epi_change_det #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pins,
  input  wire logic [W-1:0] mask,
  output logic              any_change
);
  typedef struct packed {
    logic [W-1:0] last;
  } epi_det_s;

  epi_det_s st;
  epi_det_s next_st;

  always_comb
  begin
    next_st.last = pins;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  // gated change of any unmasked pin
  assign any_change = |((pins ^ st.last) & mask);
endmodule

/* File: epi_monitor.sv */
// checker: bus handshake and request assertions for the pin interrupt unit
`timescale 1ns/1ps
module epi_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        global_irq_enable,
  input wire logic        dedicated_request,
  input wire logic        change_group_a_request,
  input wire logic        change_group_b_request,
  input wire logic [15:0] irq_vector_addr
);
  // --------
  // assertions
  // --------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_quiet;
    !dedicated_request && !change_group_a_request && !change_group_b_request;
  endsequence
  // both halves land at one edge; the response is seen two edges later
  property p_write_answer;
    s_write_taken |-> ##2 s_axi_bvalid;
  endproperty
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_ded_gate;
    !global_irq_enable [*2] |-> !dedicated_request;
  endproperty
  property p_grp_a_gate;
    !global_irq_enable [*2] |-> !change_group_a_request;
  endproperty
  property p_grp_b_gate;
    !global_irq_enable [*2] |-> !change_group_b_request;
  endproperty
  // two quiet cycles: vector must read zero
  property p_vec_idle; s_quiet [*2] |-> irq_vector_addr == 16'h0; endproperty
  property p_vec_ded;
    dedicated_request [*2] |-> irq_vector_addr == epi_pkg::PADDR_DED;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no bvalid");
  a_b_stands: assert property (p_b_stands) else $error("bvalid dropped");
  a_read_answer: assert property (p_read_answer) else $error("no rvalid");
  a_r_stands: assert property (p_r_stands) else $error("read data moved");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits set");
  a_ded_gate: assert property (p_ded_gate)
    else $error("dedicated request while gated");
  a_grp_a_gate: assert property (p_grp_a_gate)
    else $error("group a request while gated");
  a_grp_b_gate: assert property (p_grp_b_gate)
    else $error("group b request while gated");
  a_vec_idle: assert property (p_vec_idle)
    else $error("vector without request");
  a_vec_ded: assert property (p_vec_ded)
    else $error("wrong dedicated vector");
endmodule
bind epi_top epi_monitor mon_u (.*);

/* File: epi_pin_source.sv */
// partner: external sources that drive the interrupt pins
`timescale 1ns/1ps
module epi_pin_source (
  input  wire logic   aclk,
  output logic        dedicated_ext_irq,
  output logic [11:0] change_inputs_all
);
  // pins rest high, as the port pull-ups leave them
  initial
  begin
    dedicated_ext_irq = 1'h1;
    change_inputs_all = 12'hfff;
  end
  // levels held for whole clocks: shorter pulses may be missed
  task automatic drive(input logic ded, input logic [11:0] chg,
                       input int hold);
    @(posedge aclk);
    dedicated_ext_irq <= ded;
    change_inputs_all <= chg;
    repeat (hold) @(posedge aclk);
  endtask
endmodule

/* File: epi_pkg.sv */
// package: register map, field positions and encodings of the pin interrupt unit
package epi_pkg;
  // register indices as printed; byte address is index times four
  localparam logic [7:0]  IDX_MASK_A     = 8'h12;
  localparam logic [7:0]  IDX_FLAGS      = 8'h3a;
  localparam logic [7:0]  IDX_ENABLES    = 8'h3b;
  localparam logic [7:0]  IDX_MASK_B     = 8'h40;
  localparam logic [7:0]  IDX_CORE_CTRL  = 8'h41;
  localparam logic [7:0]  IDX_STATUS     = 8'h42;
  localparam logic [9:0]  ADDR_MASK_A    = {IDX_MASK_A, 2'b00};
  localparam logic [9:0]  ADDR_FLAGS     = {IDX_FLAGS, 2'b00};
  localparam logic [9:0]  ADDR_ENABLES   = {IDX_ENABLES, 2'b00};
  localparam logic [9:0]  ADDR_MASK_B    = {IDX_MASK_B, 2'b00};
  localparam logic [9:0]  ADDR_CORE_CTRL = {IDX_CORE_CTRL, 2'b00};
  localparam logic [9:0]  ADDR_STATUS    = {IDX_STATUS, 2'b00};
  // bit positions in the enable and flag registers
  localparam int          BIT_DED        = 6;
  localparam int          BIT_GRP_B      = 5;
  localparam int          BIT_GRP_A      = 4;
  localparam logic [7:0]  ENFLAG_USED    = 8'h70;
  localparam logic [7:0]  MASK_B_USED    = 8'h0f;
  localparam logic [7:0]  CORE_CTRL_USED = 8'h03;
  localparam logic [7:0]  RESET_VALUE    = 8'h00;
  // sense encodings
  localparam logic [1:0]  SENSE_LOW      = 2'b00;
  localparam logic [1:0]  SENSE_ANY      = 2'b01;
  localparam logic [1:0]  SENSE_FALL     = 2'b10;
  localparam logic [1:0]  SENSE_RISE     = 2'b11;
  // vector numbers of the three sources
  localparam logic [4:0]  VEC_DED        = 5'h02;
  localparam logic [4:0]  VEC_GRP_A      = 5'h03;
  localparam logic [4:0]  VEC_GRP_B      = 5'h04;
  localparam logic [15:0] PADDR_DED      = 16'h0001;
  localparam logic [15:0] PADDR_GRP_A    = 16'h0002;
  localparam logic [15:0] PADDR_GRP_B    = 16'h0003;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage

/* File: epi_top.sv */
// external pin interrupt unit with an AXI4-Lite register slave
//
// Contract
// - pins driven as outputs by the device still trigger enabled requests
// - group a flag rises on change of any unmasked input 0 through 7
// - group b flag rises on change of any unmasked input 8 through 11
// - pin-change detection works without the io clock, giving wake
// - low-level sense keeps requesting while the input stays low
// - low level detected without io clock and raises wake
// - edges on the dedicated input only seen while io clock runs
// - wake from low level; request only if level lasts past start-up
// - sense field: 00 low, 01 any change, 10 falling, 11 rising
// - dedicated input sampled before edge detection; one-cycle pulses caught
// - dedicated request needs enable bit 6 and global flag; own vector
// - group b request needs enable bit 5 and global flag; own vector
// - group a request needs enable bit 4 and global flag; own vector
// - flag 6 set by edge/change; cleared on handler entry or write one
// - flag 6 held cleared while level sense is selected
// - flag 5 set on group b change; cleared on entry or write one
// - flag 4 set on group a change; cleared on entry or write one
// - group b mask bits 3..0 enable detection per pin
// - group a mask bits 7..0 enable detection per pin
// - unused bits of enable and flag registers read zero
// - vectors: dedicated 0x0001, group a 0x0002, group b 0x0003
// - sleep input clamp bypassed on pins whose request is enabled
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module epi_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        dedicated_ext_irq,
  input  wire logic [11:0] change_inputs_all,
  input  wire logic        global_irq_enable,
  input  wire logic        io_clock_running,
  input  wire logic        sleep_clamp,
  input  wire logic        startup_done,
  input  wire logic        irq_ack,
  input  wire logic [4:0]  irq_ack_vector,
  output logic             dedicated_request,
  output logic             change_group_a_request,
  output logic             change_group_b_request,
  output logic [15:0]      irq_vector_addr,
  output logic             wake_request
);
  typedef struct packed {
    logic [7:0]  change_mask_a;
    logic [3:0]  change_mask_b;
    logic [2:0]  irq_enable_reg;
    logic [2:0]  irq_flag_reg;
    logic [1:0]  sense;
    logic        ded_last;
    logic        aw_held;
    logic [9:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        req_ded;
    logic        req_a;
    logic        req_b;
    logic [15:0] vec_addr;
  } epi_state_s;

  epi_state_s st;
  epi_state_s next_st;

  logic [7:0]  change_inputs_group_a;
  logic [3:0]  change_inputs_group_b;
  logic        ded_pin;
  logic        group_a_hit;
  logic        group_b_hit;
  logic        level_mode;
  logic        ded_edge;
  logic        ded_low_req;
  logic        wr_go;
  logic [7:0]  rd_byte;
  logic [7:0]  wbyte;

  // -------------------------------------------------------------------
  // pin conditioning
  // -------------------------------------------------------------------
  // inputs are read back from the pad whatever its direction, so a pin
  // driven by the device still counts
  // the sleep clamp forces pins to zero unless their request is enabled
  assign ded_pin = (sleep_clamp && !st.irq_enable_reg[2]) ? 1'b0
                 : dedicated_ext_irq;
  assign change_inputs_group_a = (sleep_clamp && !st.irq_enable_reg[0])
                               ? 8'h00 : change_inputs_all[7:0];
  assign change_inputs_group_b = (sleep_clamp && !st.irq_enable_reg[1])
                               ? 4'h0 : change_inputs_all[11:8];

  epi_change_det #(.W(8)) u_det_a (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pins       (change_inputs_group_a),
    .mask       (st.change_mask_a),
    .any_change (group_a_hit)
  );

  epi_change_det #(.W(4)) u_det_b (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .pins       (change_inputs_group_b),
    .mask       (st.change_mask_b),
    .any_change (group_b_hit)
  );

  // -------------------------------------------------------------------
  // dedicated input sense
  // -------------------------------------------------------------------
  assign level_mode = (st.sense == epi_pkg::SENSE_LOW);
  always_comb
  begin
    ded_edge = 1'b0;
    // edges compare the sampled level; io clock must run
    unique case (st.sense)
      epi_pkg::SENSE_LOW:  ded_edge = 1'b0;
      epi_pkg::SENSE_ANY:  ded_edge = ded_pin ^ st.ded_last;
      epi_pkg::SENSE_FALL: ded_edge = st.ded_last & ~ded_pin;
      epi_pkg::SENSE_RISE: ded_edge = ~st.ded_last & ded_pin;
    endcase
    ded_edge = ded_edge & io_clock_running;
  end

  // low level must still be there once start-up has finished
  assign ded_low_req = level_mode && !ded_pin && startup_done;

  // wake is combinational so it needs no running clock
  assign wake_request = (st.irq_enable_reg[2] && level_mode && !ded_pin)
                      || group_a_hit || group_b_hit;

  // -------------------------------------------------------------------
  // bus slave
  // -------------------------------------------------------------------
  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready  = !st.w_held && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  assign wr_go = st.aw_held && st.w_held && !st.bvalid;
  assign wbyte = st.w_strb[0] ? st.w_data[7:0] : 8'h00;

  always_comb
  begin
    rd_byte = 8'h00;
    // unused bits stay zero in every read
    case (s_axi_araddr)
      epi_pkg::ADDR_MASK_A:    rd_byte = st.change_mask_a;
      epi_pkg::ADDR_MASK_B:    rd_byte = {4'h0, st.change_mask_b};
      epi_pkg::ADDR_FLAGS:     rd_byte = {1'b0, st.irq_flag_reg, 4'h0};
      epi_pkg::ADDR_ENABLES:   rd_byte = {1'b0, st.irq_enable_reg, 4'h0};
      epi_pkg::ADDR_CORE_CTRL: rd_byte = {6'h00, st.sense};
      epi_pkg::ADDR_STATUS:    rd_byte = {5'h00, ded_pin, ded_edge,
                                          ded_low_req};
      default:                 rd_byte = 8'h00;
    endcase
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.ded_last = ded_pin;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h000000, rd_byte};
      next_st.rresp  = (rd_byte == 8'h00 &&
                        s_axi_araddr != epi_pkg::ADDR_MASK_A &&
                        s_axi_araddr != epi_pkg::ADDR_MASK_B &&
                        s_axi_araddr != epi_pkg::ADDR_FLAGS &&
                        s_axi_araddr != epi_pkg::ADDR_ENABLES &&
                        s_axi_araddr != epi_pkg::ADDR_CORE_CTRL &&
                        s_axi_araddr != epi_pkg::ADDR_STATUS)
                       ? epi_pkg::RESP_SLVERR : epi_pkg::RESP_OKAY;
    end
    // clears first, hardware sets below win
    if (irq_ack)
    begin
      if (irq_ack_vector == epi_pkg::VEC_DED)
        next_st.irq_flag_reg[2] = 1'b0;
      if (irq_ack_vector == epi_pkg::VEC_GRP_A)
        next_st.irq_flag_reg[0] = 1'b0;
      if (irq_ack_vector == epi_pkg::VEC_GRP_B)
        next_st.irq_flag_reg[1] = 1'b0;
    end
    if (wr_go)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = epi_pkg::RESP_OKAY;
      unique case (st.aw_addr)
        epi_pkg::ADDR_MASK_A:
          if (st.w_strb[0])
            next_st.change_mask_a = wbyte;
        epi_pkg::ADDR_MASK_B:
          if (st.w_strb[0])
            next_st.change_mask_b = wbyte[3:0];
        epi_pkg::ADDR_ENABLES:
          if (st.w_strb[0])
            next_st.irq_enable_reg = wbyte[6:4];
        epi_pkg::ADDR_CORE_CTRL:
          if (st.w_strb[0])
            next_st.sense = wbyte[1:0];
        epi_pkg::ADDR_FLAGS:
          next_st.irq_flag_reg = st.irq_flag_reg & ~wbyte[6:4];
        epi_pkg::ADDR_STATUS:
          next_st.bresp = epi_pkg::RESP_OKAY;
        default:
          next_st.bresp = epi_pkg::RESP_SLVERR;
      endcase
    end
    if (ded_edge)
      next_st.irq_flag_reg[2] = 1'b1;
    if (group_b_hit)
      next_st.irq_flag_reg[1] = 1'b1;
    if (group_a_hit)
      next_st.irq_flag_reg[0] = 1'b1;
    if (level_mode)
      next_st.irq_flag_reg[2] = 1'b0;
    // requests need the enable bit and the global flag
    next_st.req_ded = global_irq_enable && next_st.irq_enable_reg[2] &&
                      (level_mode ? ded_low_req
                                  : next_st.irq_flag_reg[2]);
    next_st.req_b = global_irq_enable && next_st.irq_enable_reg[1] &&
                    next_st.irq_flag_reg[1];
    next_st.req_a = global_irq_enable && next_st.irq_enable_reg[0] &&
                    next_st.irq_flag_reg[0];
    // fixed priority: dedicated, then group a, then group b
    if (next_st.req_ded)
      next_st.vec_addr = epi_pkg::PADDR_DED;
    else if (next_st.req_a)
      next_st.vec_addr = epi_pkg::PADDR_GRP_A;
    else if (next_st.req_b)
      next_st.vec_addr = epi_pkg::PADDR_GRP_B;
    else
      next_st.vec_addr = 16'h0000;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else
      st <= next_st;
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign dedicated_request      = st.req_ded;
  assign change_group_a_request = st.req_a;
  assign change_group_b_request = st.req_b;
  assign irq_vector_addr        = st.vec_addr;
endmodule

/* File: epi_top_test.sv */
// testbench: register access and pin interrupt scenarios for epi_top
`timescale 1ns/1ps
module epi_top_test;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [9:0]  s_axi_awaddr = 10'h0;
  logic [9:0]  s_axi_araddr = 10'h0;
  logic [2:0]  s_axi_awprot = 3'h0;
  logic [2:0]  s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        global_irq_enable = 1'h0;
  logic        io_clock_running = 1'h1;
  logic        sleep_clamp = 1'h0;
  logic        startup_done = 1'h1;
  logic        irq_ack = 1'h0;
  logic [4:0]  irq_ack_vector = 5'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, dedicated_ext_irq, dedicated_request;
  logic        change_group_a_request, change_group_b_request, wake_request;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [11:0] change_inputs_all;
  logic [15:0] irq_vector_addr;
  logic [1:0]  grp_req;
  logic [31:0] f;
  int          errors = 0;
  int          tests_run = 0;
  localparam logic [1:0] ok = epi_pkg::RESP_OKAY;
  localparam logic [9:0] flags_a = epi_pkg::ADDR_FLAGS;
  localparam logic [9:0] enab_a = epi_pkg::ADDR_ENABLES;
  localparam logic [9:0] reg_addr [5] = '{epi_pkg::ADDR_MASK_A, flags_a,
    enab_a, epi_pkg::ADDR_MASK_B, epi_pkg::ADDR_CORE_CTRL};
  localparam logic [31:0] reg_keep [5] = '{32'hff, 32'h0, 32'h70, 32'hf,
    32'h3};
  assign grp_req = {change_group_b_request, change_group_a_request};
  epi_top dut_u (.*);
  epi_pin_source src_u (.*);
  always #50 aclk = ~aclk;
  // --------
  // tasks
  // --------
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, e, s);
    end
  endtask
  // both halves offered together; each dropped once its ready is seen
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 100);
    s_axi_bready <= 1'h0;
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    // idle edge: the next call must not re-raise bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input string what, input logic [9:0] a,
                    input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 100);
    s_axi_rready <= 1'h0;
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
    chk(what, e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge aclk);
  endtask
  task automatic ack(input logic [4:0] v);
    irq_ack <= 1'h1;
    irq_ack_vector <= v;
    @(posedge aclk);
    irq_ack <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // --------
  // tests
  // --------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++)
    begin
      rd("reset value", reg_addr[i], 32'h0, ok);
      wr(reg_addr[i], 32'hffffffff, ok);
      rd("access", reg_addr[i], reg_keep[i], ok);
      wr(reg_addr[i], 32'h0, ok);
    end
    wr(10'h3fc, 32'hffffffff, epi_pkg::RESP_SLVERR);
    rd("unmapped", 10'h3fc, 32'h0, epi_pkg::RESP_SLVERR);
    $display("test registers done");
    global_irq_enable <= 1'h1;
    for (int g = 0; g < 2; g++)
    begin
      f = g ? 32'h20 : 32'h10;
      wr(g ? epi_pkg::ADDR_MASK_B : epi_pkg::ADDR_MASK_A, 32'h1, ok);
      wr(enab_a, f, ok);
      src_u.drive(1'h1, 12'hfff ^ (12'h2 << (g * 8)), 4);
      rd("masked pin", flags_a, 32'h0, ok);
      src_u.drive(1'h1, 12'hfff ^ (12'h1 << (g * 8)), 4);
      rd("group flag", flags_a, f, ok);
      chk("request", 32'h1, {31'h0, grp_req[g]});
      chk("vector", g ? 32'h3 : 32'h2, {16'h0, irq_vector_addr});
      global_irq_enable <= 1'h0;
      repeat (3) @(posedge aclk);
      chk("gated request", 32'h0, {31'h0, grp_req[g]});
      global_irq_enable <= 1'h1;
      ack(g ? epi_pkg::VEC_GRP_B : epi_pkg::VEC_GRP_A);
      rd("after entry", flags_a, 32'h0, ok);
      src_u.drive(1'h1, 12'hfff, 4);
      wr(flags_a, f, ok);
      rd("after clear", flags_a, 32'h0, ok);
      wr(enab_a, 32'h0, ok);
    end
    $display("test pin change done");
    for (int s = 1; s < 4; s++)
    begin
      wr(epi_pkg::ADDR_CORE_CTRL, 32'(s), ok);
      wr(enab_a, 32'h40, ok);
      wr(flags_a, 32'h40, ok);
      src_u.drive(1'h0, 12'hfff, 4);
      rd("falling", flags_a, s != 3 ? 32'h40 : 32'h0, ok);
      wr(flags_a, 32'h40, ok);
      src_u.drive(1'h1, 12'hfff, 4);
      rd("rising", flags_a, s != 2 ? 32'h40 : 32'h0, ok);
      chk("ded request", s != 2, {31'h0, dedicated_request});
      chk("ded vector", s != 2, {16'h0, irq_vector_addr});
      ack(epi_pkg::VEC_DED);
      rd("ded entry", flags_a, 32'h0, ok);
    end
    wr(epi_pkg::ADDR_CORE_CTRL, 32'h2, ok);
    io_clock_running <= 1'h0;
    src_u.drive(1'h0, 12'hfff, 4);
    rd("stopped clock", flags_a, 32'h0, ok);
    src_u.drive(1'h1, 12'hfff, 4);
    io_clock_running <= 1'h1;
    $display("test dedicated edges done");
    wr(epi_pkg::ADDR_CORE_CTRL, 32'h0, ok);
    startup_done <= 1'h0;
    src_u.drive(1'h0, 12'hfff, 4);
    chk("early level", 32'h0, {31'h0, dedicated_request});
    chk("wake", 32'h1, {31'h0, wake_request});
    startup_done <= 1'h1;
    repeat (4) @(posedge aclk);
    chk("level request", 32'h1, {31'h0, dedicated_request});
    rd("level flag", flags_a, 32'h0, ok);
    chk("held request", 32'h1, {31'h0, dedicated_request});
    global_irq_enable <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("gated level", 32'h0, {31'h0, dedicated_request});
    $display("test level done");
    // clamp zeroes group a (not enabled); group b passes and still sees pin 8
    wr(flags_a, 32'h70, ok);
    wr(enab_a, 32'h20, ok);
    sleep_clamp <= 1'h1;
    src_u.drive(1'h0, 12'heff, 4);
    rd("clamp", flags_a, 32'h30, ok);
    sleep_clamp <= 1'h0;
    $display("test clamp done");
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop();
  end
endmodule
